// [verilog/sltpb_map.vh]
// register map, field positions, reset values and pattern codes for the lane test block
`ifndef SLTPB_MAP_VH
`define SLTPB_MAP_VH

`define SLTPB_ADDR_DEV_CFG     12'h002
`define SLTPB_ADDR_FORMAT      12'h200
`define SLTPB_ADDR_GEOMETRY    12'h201
`define SLTPB_ADDR_STATUS      12'h204
`define SLTPB_ADDR_TEST_CTRL   12'h205
`define SLTPB_ADDR_BIND        12'h216

`define SLTPB_RST_DEV_CFG      8'h00
`define SLTPB_RST_TEST_CTRL    8'h00
`define SLTPB_RST_BIND         8'h02
`define SLTPB_RST_FORMAT       8'h1c
`define SLTPB_RST_GEOMETRY     8'h00

// device configuration fields
`define SLTPB_CFG_PD_FIRST     0
`define SLTPB_CFG_PD_SECOND    1
`define SLTPB_CFG_MODE_LO      2
`define SLTPB_CFG_MODE_HI      3
`define SLTPB_MODE_POWERDOWN   2'h3

// binding fields: set selects the second converter channel as source
`define SLTPB_BIND_FIRST       0
`define SLTPB_BIND_SECOND      1

// output format fields
`define SLTPB_FMT_CONT_LO      0
`define SLTPB_FMT_CONT_HI      1
`define SLTPB_FMT_LANES_LO     2
`define SLTPB_FMT_LANES_HI     4
`define SLTPB_FMT_SINGLE       5
`define SLTPB_FMT_CTRLBIT      6
`define SLTPB_CONT_8           2'h0
`define SLTPB_CONT_12          2'h1
`define SLTPB_CONT_16          2'h2

// geometry fields: converters-1, log2 samples, words per lane-1; K-1 is written at the status address
`define SLTPB_GEO_M_LO         0
`define SLTPB_GEO_M_HI         1
`define SLTPB_GEO_SLOG_LO      2
`define SLTPB_GEO_SLOG_HI      3
`define SLTPB_GEO_W_LO         4
`define SLTPB_GEO_W_HI         5
`define SLTPB_K_RST            5'h00

// test pattern select codes
`define SLTPB_TP_NORMAL        4'h0
`define SLTPB_TP_PRBS7         4'h1
`define SLTPB_TP_PRBS15        4'h2
`define SLTPB_TP_PRBS23        4'h3
`define SLTPB_TP_RAMP          4'h4
`define SLTPB_TP_TRANSPORT     4'h5

`define SLTPB_PRBS_ORDER7      2'h0
`define SLTPB_PRBS_ORDER15     2'h1
`define SLTPB_PRBS_ORDER23     2'h2

`define SLTPB_LANES            16
`define SLTPB_LANES_PER_LINK   8
`define SLTPB_SHORT12_TAIL     4'h0

`endif

// [verilog/sltpb_prbs.v]
// per-lane pseudo-random generator, eight bits per clock, oldest bit in the msb
`timescale 1ns/1ps
module sltpb_prbs #(
    parameter [22:0] SEED = 23'h000001
) (
    input  wire       clk_sys,
    input  wire       sys_rst,
    input  wire       run,
    input  wire [1:0] order,
    output wire [7:0] octet
);
    `include "sltpb_map.vh"

    reg  [22:0] history;
    reg  [22:0] next_history;
    reg  [7:0]  bits;
    reg         newBit;
    integer     i;

    // each new bit is the xor of two earlier transmitted bits
    always @* begin
        next_history = history;
        bits = 8'h00;
        newBit = 1'b0;
        for (i = 0; i < 8; i = i + 1) begin
            case (order)
                `SLTPB_PRBS_ORDER7:  newBit = next_history[5] ^ next_history[6];
                `SLTPB_PRBS_ORDER15: newBit = next_history[13] ^ next_history[14];
                default:             newBit = next_history[17] ^ next_history[22];
            endcase
            next_history = {next_history[21:0], newBit};
            bits[7 - i] = newBit;
        end
    end

    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            history <= SEED;
        end else if (run) begin
            history <= next_history;
        end
    end

    assign octet = bits;
endmodule

// [verilog/sltpb_top.v]
// lane mapping, channel binding, power-down and test pattern generation for sixteen serial lanes
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
module sltpb_top (
    input  wire         clk_sys,
    input  wire         sys_rst,
    input  wire [11:0]  regAddr,
    input  wire [7:0]   regWrData,
    input  wire         regWrEn,
    input  wire         regRdEn,
    output reg  [7:0]   regRdData,
    input  wire         powerdownPin,
    input  wire         linkDataPhase,
    input  wire [63:0]  sampleFirst,
    input  wire [63:0]  sampleSecond,
    output reg  [127:0] laneData,
    output reg  [15:0]  laneDriverEnable,
    output reg          encoderBypass,
    output reg          powerdownFirstChannel,
    output reg          powerdownSecondChannel,
    output reg          linkRestart
);
    `include "sltpb_map.vh"

    reg  [7:0]   deviceConfiguration;
    reg  [7:0]   linkTestPatternControl;
    reg  [7:0]   digitalChannelBinding;
    reg  [7:0]   outputFormatSelect;
    reg  [7:0]   formatGeometry;
    reg  [4:0]   framesPerMultiframe;
    reg          pdSync1;
    reg          pdSync2;
    reg          pdAllDly;
    reg  [7:0]   rampCount;
    reg  [2:0]   octetCount;
    reg  [6:0]   frameCount;
    reg  [6:0]   patternFrames;
    reg  [2:0]   frameOctets;
    reg  [7:0]   next_rdData;
    reg  [31:0]  frameSpan;

    wire [3:0]   testPatternSelect = linkTestPatternControl[3:0];
    wire [1:0]   cfgMode = deviceConfiguration[`SLTPB_CFG_MODE_HI:`SLTPB_CFG_MODE_LO];
    wire [1:0]   container = outputFormatSelect[`SLTPB_FMT_CONT_HI:`SLTPB_FMT_CONT_LO];
    wire [2:0]   lanesCode = outputFormatSelect[`SLTPB_FMT_LANES_HI:`SLTPB_FMT_LANES_LO];
    wire         singleChannel = outputFormatSelect[`SLTPB_FMT_SINGLE];
    wire         ctrlBitsOn = outputFormatSelect[`SLTPB_FMT_CTRLBIT];
    wire [2:0]   convCount = {1'b0, formatGeometry[`SLTPB_GEO_M_HI:`SLTPB_GEO_M_LO]} + 3'h1;
    wire [1:0]   sampleLog2 = formatGeometry[`SLTPB_GEO_SLOG_HI:`SLTPB_GEO_SLOG_LO];
    wire [2:0]   wordsPerLane = {1'b0, formatGeometry[`SLTPB_GEO_W_HI:`SLTPB_GEO_W_LO]} + 3'h1;
    wire [5:0]   kFrames = {1'b0, framesPerMultiframe} + 6'h01;
    wire [5:0]   convTimesSamples = {3'h0, convCount} << sampleLog2;
    wire         isPrbs = (testPatternSelect == `SLTPB_TP_PRBS7) ||
                          (testPatternSelect == `SLTPB_TP_PRBS15) ||
                          (testPatternSelect == `SLTPB_TP_PRBS23);
    wire [1:0]   prbsOrder = testPatternSelect[1:0] - 2'h1;
    // pin or mode field forces full power-down
    wire         pdAll = pdSync2 || (cfgMode == `SLTPB_MODE_POWERDOWN);
    wire         lastOctet = (octetCount == frameOctets - 3'h1);
    wire [127:0] nextLaneData;
    wire [15:0]  next_driverEnable;
    wire [63:0]  pathFirst;
    wire [63:0]  pathSecond;

    // register writes; the pattern select is taken at once, so changing it on a live link corrupts frames
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            deviceConfiguration <= `SLTPB_RST_DEV_CFG;
            linkTestPatternControl <= `SLTPB_RST_TEST_CTRL;
            digitalChannelBinding <= `SLTPB_RST_BIND;
            outputFormatSelect <= `SLTPB_RST_FORMAT;
            formatGeometry <= `SLTPB_RST_GEOMETRY;
            framesPerMultiframe <= `SLTPB_K_RST;
        end else if (regWrEn) begin
            if (regAddr == `SLTPB_ADDR_DEV_CFG) begin
                deviceConfiguration <= regWrData;
            end else if (regAddr == `SLTPB_ADDR_TEST_CTRL) begin
                linkTestPatternControl <= regWrData;
            end else if (regAddr == `SLTPB_ADDR_BIND) begin
                digitalChannelBinding <= regWrData;
            end else if (regAddr == `SLTPB_ADDR_FORMAT) begin
                outputFormatSelect <= regWrData;
            end else if (regAddr == `SLTPB_ADDR_GEOMETRY) begin
                formatGeometry <= regWrData;
            end else if (regAddr == `SLTPB_ADDR_STATUS) begin
                framesPerMultiframe <= regWrData[4:0];
            end
        end
    end

    // status byte doubles as the K register on write; reads show live state above bit 4
    always @* begin
        next_rdData = 8'h00;
        if (regAddr == `SLTPB_ADDR_DEV_CFG) begin
            next_rdData = deviceConfiguration;
        end else if (regAddr == `SLTPB_ADDR_TEST_CTRL) begin
            next_rdData = linkTestPatternControl;
        end else if (regAddr == `SLTPB_ADDR_BIND) begin
            next_rdData = digitalChannelBinding;
        end else if (regAddr == `SLTPB_ADDR_FORMAT) begin
            next_rdData = outputFormatSelect;
        end else if (regAddr == `SLTPB_ADDR_GEOMETRY) begin
            next_rdData = formatGeometry;
        end else if (regAddr == `SLTPB_ADDR_STATUS) begin
            next_rdData = {pdAll, isPrbs, linkDataPhase, framesPerMultiframe};
        end
    end

    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            regRdData <= 8'h00;
        end else if (regRdEn) begin
            regRdData <= next_rdData;
        end else begin
            regRdData <= 8'h00;
        end
    end

    // pin is asynchronous to the clock
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            pdSync1 <= 1'b0;
            pdSync2 <= 1'b0;
            pdAllDly <= 1'b0;
            linkRestart <= 1'b0;
            powerdownFirstChannel <= 1'b0;
            powerdownSecondChannel <= 1'b0;
        end else begin
            pdSync1 <= powerdownPin;
            pdSync2 <= pdSync1;
            pdAllDly <= pdAll;
            // one-cycle request to rebuild the link on power-down exit
            linkRestart <= pdAllDly && !pdAll;
            // unused converter channel may be switched off
            powerdownFirstChannel <= deviceConfiguration[`SLTPB_CFG_PD_FIRST] || pdAll;
            powerdownSecondChannel <= deviceConfiguration[`SLTPB_CFG_PD_SECOND] || pdAll;
        end
    end

    // smallest multiple of K covering M*S+2 frames
    integer n;
    always @* begin
        patternFrames = 7'h00;
        frameSpan = 32'h0;
        for (n = 34; n >= 1; n = n - 1) begin
            frameSpan = kFrames * n;
            // largest legal span is 64 frames, so seven bits suffice
            if (frameSpan >= ({26'h0, convTimesSamples} + 32'h2)) begin
                patternFrames = frameSpan[6:0];
            end
        end
        // short patterns repeat every one or two frames
        case (container)
            `SLTPB_CONT_8: begin
                patternFrames = 7'h02;
                frameOctets = 3'h1;
            end
            `SLTPB_CONT_12: begin
                patternFrames = 7'h01;
                frameOctets = 3'h0;
            end
            default: begin
                frameOctets = {wordsPerLane[1:0], 1'b0};
            end
        endcase
    end

    // frame counters held at zero until alignment is over
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            octetCount <= 3'h0;
            frameCount <= 7'h00;
            rampCount <= 8'h00;
        end else if (!linkDataPhase) begin
            octetCount <= 3'h0;
            frameCount <= 7'h00;
            rampCount <= 8'h00;
        end else begin
            // free-running octet ramp wraps at 0xff
            rampCount <= rampCount + 8'h01;
            octetCount <= lastOctet ? 3'h0 : octetCount + 3'h1;
            if (lastOctet) begin
                frameCount <= (frameCount == patternFrames - 7'h01) ? 7'h00 : frameCount + 7'h01;
            end
        end
    end

    // binding bits pick each path's source converter channel while the single-channel bit is clear
    assign pathFirst = (!singleChannel && digitalChannelBinding[`SLTPB_BIND_FIRST]) ? sampleSecond : sampleFirst;
    assign pathSecond = (singleChannel || digitalChannelBinding[`SLTPB_BIND_SECOND]) ? sampleSecond : sampleFirst;

    genvar g;
    generate
        for (g = 0; g < `SLTPB_LANES; g = g + 1) begin : lane
            localparam [31:0] LANE_IN_LINK = g % `SLTPB_LANES_PER_LINK;
            localparam [2:0]  LIDX = LANE_IN_LINK[2:0];
            localparam [31:0] SEED_WIDE = (32'h0000a5a5 + g * 32'h00001357) | 32'h00000001;
            wire [7:0]  prbsOctet;
            wire [7:0]  normalOctet;
            wire [63:0] short12Row;
            reg  [7:0]  octetOut;
            reg  [4:0]  wordIdx;
            reg  [4:0]  convIdx;
            reg  [4:0]  sidIdx;
            reg  [15:0] baseWord;
            reg  [15:0] longWord;
            reg         ctrlBit;

            // distinct seed per lane gives a distinct start phase
            sltpb_prbs #(
                .SEED(SEED_WIDE[22:0])
            ) prbsGen (
                .clk_sys(clk_sys),
                .sys_rst(sys_rst),
                .run(isPrbs),
                .order(prbsOrder),
                .octet(prbsOctet)
            );

            // lane k of each link carries sample k of its path
            assign normalOctet = (g < `SLTPB_LANES_PER_LINK) ? pathFirst[8 * LIDX +: 8] : pathSecond[8 * LIDX +: 8];

            // five words of nibbles 15-j, j and index 1..5, then tail
            assign short12Row = {~{1'b0, LIDX}, {1'b0, LIDX}, 4'h1, ~{1'b0, LIDX}, {1'b0, LIDX}, 4'h2,
                                 ~{1'b0, LIDX}, {1'b0, LIDX}, 4'h3, ~{1'b0, LIDX}, {1'b0, LIDX}, 4'h4,
                                 ~{1'b0, LIDX}, {1'b0, LIDX}, 4'h5, `SLTPB_SHORT12_TAIL};

            always @* begin
                wordIdx = LIDX * wordsPerLane + {2'h0, octetCount[2:1]};
                convIdx = wordIdx >> sampleLog2;
                sidIdx = wordIdx & ((5'h01 << sampleLog2) - 5'h01);
                // converter index, then sample index, then half scale
                if (frameCount == 7'h00) begin
                    baseWord = {11'h000, convIdx} + 16'h0001;
                end else if (frameCount == 7'h01) begin
                    baseWord = {11'h000, sidIdx} + 16'h0001;
                end else begin
                    baseWord = ctrlBitsOn ? 16'h4000 : 16'h8000;
                end
                // walking control bit for the first M*S frames
                ctrlBit = (frameCount < {1'b0, convTimesSamples}) && (frameCount == {2'h0, wordIdx});
                longWord = ctrlBitsOn ? {baseWord[14:0], ctrlBit} : baseWord;
                octetOut = 8'h00;
                case (testPatternSelect)
                    `SLTPB_TP_NORMAL: octetOut = normalOctet;
                    `SLTPB_TP_PRBS7, `SLTPB_TP_PRBS15, `SLTPB_TP_PRBS23: octetOut = prbsOctet;
                    `SLTPB_TP_RAMP: octetOut = rampCount;
                    `SLTPB_TP_TRANSPORT: begin
                        if (container == `SLTPB_CONT_8) begin
                            // k then complement, both links alike
                            octetOut = frameCount[0] ? ~{5'h00, LIDX} : {5'h00, LIDX};
                        end else if (container == `SLTPB_CONT_12) begin
                            octetOut = short12Row[63 - 8 * octetCount -: 8];
                        end else begin
                            // same long pattern on both links
                            octetOut = octetCount[0] ? longWord[7:0] : longWord[15:8];
                        end
                    end
                    default: octetOut = 8'h00;
                endcase
            end

            // lane powered only if the format uses it
            // unused higher lanes stay dark for every pattern
            assign next_driverEnable[g] = (LIDX <= lanesCode) && !pdAll;
            assign nextLaneData[8 * g +: 8] = next_driverEnable[g] ? octetOut : 8'h00;
        end
    endgenerate

    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            laneData <= 128'h0;
            laneDriverEnable <= 16'h0000;
            encoderBypass <= 1'b0;
        end else begin
            laneData <= nextLaneData;
            laneDriverEnable <= next_driverEnable;
            encoderBypass <= isPrbs;
        end
    end
endmodule

// [dv/sltpb_top_sva.sv]
// port assertions for the lane test block
`timescale 1ns/1ps
module sltpb_top_sva (
    input wire         clk_sys,
    input wire         sys_rst,
    input wire [11:0]  regAddr,
    input wire [7:0]   regWrData,
    input wire         regWrEn,
    input wire         regRdEn,
    input wire [7:0]   regRdData,
    input wire         powerdownPin,
    input wire         linkDataPhase,
    input wire [63:0]  sampleFirst,
    input wire [63:0]  sampleSecond,
    input wire [127:0] laneData,
    input wire [15:0]  laneDriverEnable,
    input wire         encoderBypass,
    input wire         powerdownFirstChannel,
    input wire         powerdownSecondChannel,
    input wire         linkRestart
);
    logic [3:0] testMode;
    logic [7:0] bindReg;

    // shadow copies so lane properties know the selected mode
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            testMode <= 4'h0;
            bindReg <= 8'h02;
        end else if (regWrEn && regAddr == 12'h205) begin
            testMode <= regWrData[3:0];
        end else if (regWrEn && regAddr == 12'h216) begin
            bindReg <= regWrData;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    a_rd_idle: assert property (
        !$past(regRdEn) |-> regRdData == 8'h00) else $error("read data outside its slot");
    a_pd_pin: assert property (
        powerdownPin [*4] |-> laneDriverEnable == 16'h0000) else $error("drivers on while pin low power");
    a_pd_mode: assert property (
        regWrEn && regAddr == 12'h002 && regWrData[3:2] == 2'h3 |-> ##2 laneDriverEnable == 16'h0000)
        else $error("drivers on in power-down mode");
    a_cfg_pd: assert property (
        regWrEn && regAddr == 12'h002 && regWrData[3:0] == 4'h2
        |-> ##[1:2] powerdownSecondChannel && !powerdownFirstChannel) else $error("channel power-down wrong");
    a_bypass_on: assert property (
        regWrEn && regAddr == 12'h205 && regWrData inside {8'h01, 8'h02, 8'h03} |-> ##[1:2] encoderBypass)
        else $error("encoder not bypassed");
    a_restart_pulse: assert property (
        linkRestart |=> !linkRestart) else $error("restart longer than one cycle");
    a_ramp_step: assert property (
        $past(testMode) == 4'h4 && testMode == 4'h4 && $past(linkDataPhase) && laneDriverEnable[0]
        |=> laneData[7:0] == $past(laneData[7:0]) + 8'h01) else $error("ramp did not step");
    a_lane_off: assert property (
        !laneDriverEnable[15] |-> laneData[127:120] == 8'h00) else $error("data on disabled lane");
    a_bind_first: assert property (
        testMode == 4'h0 && !bindReg[0] && laneDriverEnable[0]
        |=> !laneDriverEnable[0] || laneData[7:0] == $past(sampleFirst[7:0])) else $error("lane A0 not sample 0");
endmodule

bind sltpb_top sltpb_top_sva sltpb_top_sva_i (.clk_sys, .sys_rst, .regAddr, .regWrData, .regWrEn, .regRdEn,
    .regRdData, .powerdownPin, .linkDataPhase, .sampleFirst, .sampleSecond, .laneData, .laneDriverEnable,
    .encoderBypass, .powerdownFirstChannel, .powerdownSecondChannel, .linkRestart);

// [dv/sltpb_rx_model.sv]
// receiver model: self-synchronising sequence check on link A lane 0
`timescale 1ns/1ps
module sltpb_rx_model (
    input wire       clk_sys,
    input wire       sys_rst,
    input wire [7:0] laneOctet,
    input wire       laneOn,
    input wire       bypass,
    input wire [1:0] order,
    output int       rxErrors,
    output int       rxChecks
);
    logic [22:0] hist;
    int          seen;
    int          flush;
    int          ta;
    int          tb;

    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            rxErrors = 0;
            rxChecks = 0;
            seen = 0;
            flush = 8;
        end else begin
            ta = (order == 2'h0) ? 6 : (order == 2'h1) ? 14 : 18;
            tb = (order == 2'h0) ? 7 : (order == 2'h1) ? 15 : 23;
            // stale octets after power-down are dropped
            if (!laneOn) flush = 8;
            else if (flush > 0) flush--;
            if (!bypass || flush != 0) seen = 0;
            else begin
                // phase unknown, so lock on history first
                for (int i = 7; i >= 0; i--) begin
                    if (seen >= 23) begin
                        rxChecks++;
                        if (laneOctet[i] !== (hist[ta-1] ^ hist[tb-1])) rxErrors++;
                    end
                    hist = {hist[21:0], laneOctet[i]};
                    seen++;
                end
            end
        end
    end
endmodule

// [dv/sltpb_top_tb.sv]
// self-checking bench for the lane test block
`timescale 1ns/1ps
`include "sltpb_map.vh"
module sltpb_top_tb;
    logic         clk_sys = 1'b0;
    logic         sys_rst = 1'b1;
    logic [11:0]  regAddr = 12'h000;
    logic [7:0]   regWrData = 8'h00;
    logic         regWrEn = 1'b0;
    logic         regRdEn = 1'b0;
    logic         powerdownPin = 1'b0;
    logic         linkDataPhase = 1'b0;
    logic [63:0]  sampleFirst = 64'h0;
    logic [63:0]  sampleSecond = 64'h0;
    logic [1:0]   prbsOrder = 2'h0;
    logic [127:0] acc;
    wire  [7:0]   regRdData;
    wire  [127:0] laneData;
    wire  [15:0]  laneDriverEnable;
    wire          encoderBypass;
    wire          powerdownFirstChannel;
    wire          powerdownSecondChannel;
    wire          linkRestart;
    int           rxErrors;
    int           rxChecks;
    int           miscompares = 0;
    int           comparisons = 0;
    int           seed = 32'hc79e;

    always #12.5 clk_sys = ~clk_sys;

    sltpb_top sltpb_top_i (.clk_sys, .sys_rst, .regAddr, .regWrData, .regWrEn, .regRdEn, .regRdData,
        .powerdownPin, .linkDataPhase, .sampleFirst, .sampleSecond, .laneData, .laneDriverEnable,
        .encoderBypass, .powerdownFirstChannel, .powerdownSecondChannel, .linkRestart);
    sltpb_rx_model sltpb_rx_model_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .laneOctet(laneData[7:0]),
        .laneOn(laneDriverEnable[0]), .bypass(encoderBypass), .order(prbsOrder), .rxErrors(rxErrors),
        .rxChecks(rxChecks));

    task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        regAddr <= a;
        regWrData <= d;
        regWrEn <= 1'b1;
        @(posedge clk_sys);
        regWrEn <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        regAddr <= a;
        regRdEn <= 1'b1;
        @(posedge clk_sys);
        regRdEn <= 1'b0;
        #1;
        chk(regRdData, e);
    endtask

    // pattern only changes while the link is held out of data phase
    task automatic setTest(input logic [7:0] c);
        @(posedge clk_sys);
        linkDataPhase <= 1'b0;
        wr(`SLTPB_ADDR_TEST_CTRL, c);
        cyc(3);
        @(posedge clk_sys);
        linkDataPhase <= 1'b1;
        cyc(1);
    endtask

    task automatic waitRestart();
        int n;
        n = 0;
        while (linkRestart !== 1'b1 && n < 10) begin
            cyc(1);
            n++;
        end
    endtask

    function automatic logic [127:0] mapped(input int b, input bit sg);
        mapped = {(b / 2 == 1 || sg) ? sampleSecond : sampleFirst, (b % 2 == 1 && !sg) ? sampleSecond : sampleFirst};
    endfunction

    function automatic logic [127:0] short8(input int f);
        for (int g = 0; g < 16; g++)
            short8[8*g +: 8] = (g % 8 > 3) ? 8'h00 : (f % 2 == 1) ? ~8'(g % 8) : 8'(g % 8);
    endfunction

    function automatic logic [127:0] short12(input int o);
        logic [63:0] row;
        for (int g = 0; g < 16; g++) begin
            for (int w = 0; w < 5; w++)
                row[63-12*w -: 12] = {4'(15 - g % 8), 4'(g % 8), 4'(w + 1)};
            row[3:0] = `SLTPB_SHORT12_TAIL;
            short12[8*g +: 8] = row[63-8*(o%8) -: 8];
        end
    endfunction

    // m converters of one sample each; lane j of both links carries converter j
    function automatic logic [127:0] long16(input int i, input int k, input int m, input bit cb);
        int          len;
        int          f;
        logic [15:0] w;
        len = k * ((m + 2 + k - 1) / k);
        f = (i / 2) % len;
        long16 = '0;
        for (int j = 0; j < m; j++) begin
            w = (f == 0) ? 16'(j + 1) : (f == 1) ? 16'h0001 : (cb ? 16'h4000 : 16'h8000);
            if (cb)
                w = {w[14:0], f == j};
            long16[8*j +: 8] = (i % 2 == 0) ? w[15:8] : w[7:0];
            long16[64+8*j +: 8] = long16[8*j +: 8];
        end
    endfunction

    task automatic results();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial begin
        #(25ns * 8000);
        miscompares++;
        results();
    end

    initial begin
        repeat (3) @(posedge clk_sys);
        sys_rst <= 1'b0;
        rd(`SLTPB_ADDR_DEV_CFG, 8'h00);
        rd(`SLTPB_ADDR_TEST_CTRL, 8'h00);
        rd(`SLTPB_ADDR_BIND, 8'h02);
        rd(12'h3ff, 8'h00);
        for (int p = 1; p < 4; p++) begin
            wr(`SLTPB_ADDR_DEV_CFG, 8'(p));
            cyc(2);
            chk({powerdownSecondChannel, powerdownFirstChannel}, p);
        end
        wr(`SLTPB_ADDR_DEV_CFG, 8'h0c);
        cyc(2);
        chk(laneDriverEnable, 16'h0000);
        chk(laneData, 0);
        chk({powerdownSecondChannel, powerdownFirstChannel}, 2'h3);
        wr(`SLTPB_ADDR_DEV_CFG, 8'h00);
        waitRestart();
        chk(linkRestart, 1'b1);
        @(posedge clk_sys);
        powerdownPin <= 1'b1;
        cyc(4);
        chk(laneDriverEnable, 16'h0000);
        @(posedge clk_sys);
        powerdownPin <= 1'b0;
        waitRestart();
        chk(linkRestart, 1'b1);
        cyc(2);
        chk(laneDriverEnable, 16'hffff);
        for (int m = 0; m < 8; m++) begin
            wr(`SLTPB_ADDR_BIND, 8'(m % 4));
            wr(`SLTPB_ADDR_FORMAT, (m > 3) ? 8'h3c : 8'h1c);
            repeat (4) begin
                @(posedge clk_sys);
                sampleFirst <= {$random(seed), $random(seed)};
                sampleSecond <= {$random(seed), $random(seed)};
                cyc(2);
                chk(laneData, mapped(m % 4, m > 3));
            end
        end
        setTest(8'h04);
        for (int i = 0; i < 260; i++) begin
            chk(laneData, {16{i[7:0]}});
            cyc(1);
        end
        for (int o = 0; o < 3; o++) begin
            prbsOrder = 2'(o);
            setTest(8'(o + 1));
            chk(encoderBypass, 1'b1);
            acc = '0;
            repeat (8) begin
                acc = acc | (laneData[7:0] ^ laneData[15:8]);
                cyc(1);
            end
            chk(acc != 0, 1'b1);
            cyc(200);
            setTest(8'h00);
            chk(encoderBypass, 1'b0);
        end
        chk(rxErrors, 0);
        chk(rxChecks > 1000, 1'b1);
        wr(`SLTPB_ADDR_FORMAT, 8'h0c);
        setTest(8'h05);
        for (int f = 0; f < 6; f++) begin
            chk(laneData, short8(f));
            cyc(1);
        end
        wr(`SLTPB_ADDR_FORMAT, 8'h1d);
        setTest(8'h05);
        for (int o = 0; o < 16; o++) begin
            chk(laneData, short12(o));
            cyc(1);
        end
        wr(`SLTPB_ADDR_FORMAT, 8'h02);
        for (int k = 1; k < 4; k++) begin
            // last pass: two converters on two lanes, control bits present
            if (k == 3) begin
                wr(`SLTPB_ADDR_FORMAT, 8'h46);
                wr(`SLTPB_ADDR_GEOMETRY, 8'h01);
            end
            wr(`SLTPB_ADDR_STATUS, 8'(k - 1));
            setTest(8'h05);
            for (int i = 0; i < 24; i++) begin
                chk(laneData, long16(i, k, (k == 3) ? 2 : 1, k == 3));
                cyc(1);
            end
        end
        for (int c = 0; c < 8; c++) begin
            wr(`SLTPB_ADDR_FORMAT, 8'(c << 2));
            cyc(2);
            chk(laneDriverEnable, {2{8'((1 << (c + 1)) - 1)}});
        end
        results();
    end
endmodule
